/* port_prio_pkg.sv */
// shared constants and types for the per-port priority register bank
package port_prio_pkg;

  // ****************************************
  // register offsets (byte addresses)
  // ****************************************
  localparam logic [11:0] off_block_usage  = 12'h004;
  localparam logic [11:0] off_default_tag  = 12'h008;
  localparam logic [11:0] off_tx_remap     = 12'h00c;
  localparam logic [11:0] off_prio_control = 12'h010;
  localparam logic [11:0] off_rx_remap     = 12'h014;

  // ****************************************
  // field positions and widths
  // ****************************************
  localparam int rx_blk_lsb     = 0;
  localparam int rx_blk_w       = 6;
  localparam int tx_blk_lsb     = 8;
  localparam int tx_blk_w       = 5;
  localparam int tag_vid_lsb    = 0;
  localparam int tag_cfi_bit    = 12;
  localparam int tag_pri_lsb    = 13;
  localparam int remap_stride   = 4;
  localparam int rlim_lsb       = 0;
  localparam int arb_type_bit   = 8;
  localparam int host_thr_lsb   = 12;
  localparam int rx_pfc_lsb     = 16;
  localparam int tx_pfc_lsb     = 24;
  localparam int num_prio       = 8;

  // ****************************************
  // reset values and write masks
  // ****************************************
  localparam logic [5:0]  rx_blk_reset   = 6'h01;
  localparam logic [4:0]  tx_blk_reset   = 5'h00;
  localparam logic [3:0]  host_thr_reset = 4'h9;
  localparam logic [31:0] remap_identity = 32'h7654_3210;
  localparam logic [31:0] remap_mask     = 32'h7777_7777;
  localparam logic [31:0] tag_mask       = 32'h0000_ffff;
  localparam logic [31:0] host_ctl_mask  = 32'h00ff_01ff;
  localparam logic [31:0] ext_ctl_mask   = 32'hffff_f0ff;
  localparam logic [31:0] ext_ctl_reset  = 32'h0000_9000;
  localparam logic [31:0] zero_word      = 32'h0000_0000;

  // ****************************************
  // types
  // ****************************************
  typedef struct packed {
    logic [11:0] addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
  } reg_req_t;

  typedef struct packed {
    logic [7:0] rx_pfc_enable;
    logic [7:0] tx_pfc_enable;
    logic       rx_round_robin;
    logic [7:0] host_ingress_limited;
    logic [7:0] ext_egress_limited;
    logic [3:0] host_send_free_block_threshold;
  } prio_ctl_t;

endpackage

/* switch_port_priority_regs.sv */
// per-port priority, tag and block-usage register bank of a switch port
//
// The plain strobed port and the address map were decided locally.
module switch_port_priority_regs #(
  parameter bit IS_HOST_PORT = 1'b0
) (
  input  wire logic                            clock,
  input  wire logic                            rst_b,
  input  wire logic                            clk_en,
  input  wire port_prio_pkg::reg_req_t         reg_req,
  output logic [31:0]                          reg_rdata,
  input  wire logic                            rx_blocks_update,
  input  wire logic [5:0]                      rx_blocks_value,
  input  wire logic                            tx_blocks_update,
  input  wire logic [4:0]                      tx_blocks_value,
  input  wire logic [2:0]                      tx_hdr_priority,
  output logic [2:0]                           tx_switch_priority,
  input  wire logic [2:0]                      rx_pkt_priority,
  output logic [2:0]                           rx_hdr_priority,
  input  wire logic [4:0]                      free_tx_blocks,
  output logic                                 host_send_allowed,
  output logic [15:0]                          default_tag,
  output port_prio_pkg::prio_ctl_t             prio_ctl
);

  // ****************************************
  // storage
  // ****************************************
  logic [5:0]  rx_fifo_blocks_used;
  logic [4:0]  tx_fifo_blocks_used;
  logic [31:0] tag_reg;
  logic [31:0] tx_remap;
  logic [31:0] rx_remap;
  logic [31:0] ctl_reg;

  logic [31:0] ctl_mask;
  logic [31:0] ctl_reset;

  assign ctl_mask  = IS_HOST_PORT ? port_prio_pkg::host_ctl_mask : port_prio_pkg::ext_ctl_mask;
  assign ctl_reset = IS_HOST_PORT ? port_prio_pkg::zero_word : port_prio_pkg::ext_ctl_reset;

  function automatic logic [2:0] remap_lookup(input logic [31:0] table_word,
                                              input logic [2:0]  index);
    logic [31:0] shifted;
    shifted = table_word >> (index * port_prio_pkg::remap_stride);
    return shifted[2:0];
  endfunction

  function automatic logic hit(input logic [11:0] a, input logic [11:0] off);
    return a == off;
  endfunction

  // ****************************************
  // block usage status
  // ****************************************
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      rx_fifo_blocks_used <= port_prio_pkg::rx_blk_reset;
    end else if (clk_en && rx_blocks_update) begin
      rx_fifo_blocks_used <= rx_blocks_value;
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_b) begin
      tx_fifo_blocks_used <= port_prio_pkg::tx_blk_reset;
    end else if (clk_en && tx_blocks_update) begin
      tx_fifo_blocks_used <= tx_blocks_value;
    end
  end

  // ****************************************
  // writable registers
  // ****************************************
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      tag_reg <= port_prio_pkg::zero_word;
    end else if (clk_en && reg_req.wr && hit(reg_req.addr, port_prio_pkg::off_default_tag)) begin
      tag_reg <= reg_req.wdata & port_prio_pkg::tag_mask;
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_b) begin
      tx_remap <= port_prio_pkg::remap_identity;
    end else if (clk_en && reg_req.wr && hit(reg_req.addr, port_prio_pkg::off_tx_remap)) begin
      tx_remap <= reg_req.wdata & port_prio_pkg::remap_mask;
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_b) begin
      rx_remap <= port_prio_pkg::remap_identity;
    end else if (clk_en && reg_req.wr && hit(reg_req.addr, port_prio_pkg::off_rx_remap)) begin
      rx_remap <= reg_req.wdata & port_prio_pkg::remap_mask;
    end
  end

  // layout depends on host or external port; reserved bits held at zero
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      ctl_reg <= ctl_reset;
    end else if (clk_en && reg_req.wr && hit(reg_req.addr, port_prio_pkg::off_prio_control)) begin
      ctl_reg <= reg_req.wdata & ctl_mask;
    end
  end

  // ****************************************
  // read port, data one cycle after strobe
  // ****************************************
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      reg_rdata <= port_prio_pkg::zero_word;
    end else if (clk_en) begin
      if (!reg_req.rd) begin
        reg_rdata <= port_prio_pkg::zero_word;
      end else if (hit(reg_req.addr, port_prio_pkg::off_block_usage)) begin
        reg_rdata <= port_prio_pkg::zero_word;
        reg_rdata[port_prio_pkg::rx_blk_lsb +: port_prio_pkg::rx_blk_w] <=
          rx_fifo_blocks_used;
        reg_rdata[port_prio_pkg::tx_blk_lsb +: port_prio_pkg::tx_blk_w] <=
          tx_fifo_blocks_used;
      end else if (hit(reg_req.addr, port_prio_pkg::off_default_tag)) begin
        reg_rdata <= tag_reg;
      end else if (hit(reg_req.addr, port_prio_pkg::off_tx_remap)) begin
        reg_rdata <= tx_remap;
      end else if (hit(reg_req.addr, port_prio_pkg::off_prio_control)) begin
        reg_rdata <= ctl_reg;
      end else if (hit(reg_req.addr, port_prio_pkg::off_rx_remap)) begin
        reg_rdata <= rx_remap;
      end else begin
        reg_rdata <= port_prio_pkg::zero_word;
      end
    end
  end

  // ****************************************
  // datapath outputs
  // ****************************************
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      tx_switch_priority <= 3'h0;
      rx_hdr_priority    <= 3'h0;
    end else if (clk_en) begin
      tx_switch_priority <= remap_lookup(tx_remap, tx_hdr_priority);
      rx_hdr_priority    <= remap_lookup(rx_remap, rx_pkt_priority);
    end
  end

  assign default_tag = tag_reg[15:0];

  always_comb begin
    prio_ctl = '0;
    prio_ctl.rx_pfc_enable = ctl_reg[port_prio_pkg::rx_pfc_lsb +: port_prio_pkg::num_prio];
    if (IS_HOST_PORT) begin
      prio_ctl.rx_round_robin = ctl_reg[port_prio_pkg::arb_type_bit];
      // thermometer bits map one-to-one onto channels; egress never limited
      prio_ctl.host_ingress_limited =
        ctl_reg[port_prio_pkg::rlim_lsb +: port_prio_pkg::num_prio];
    end else begin
      prio_ctl.tx_pfc_enable = ctl_reg[port_prio_pkg::tx_pfc_lsb +: port_prio_pkg::num_prio];
      prio_ctl.ext_egress_limited =
        ctl_reg[port_prio_pkg::rlim_lsb +: port_prio_pkg::num_prio];
      prio_ctl.host_send_free_block_threshold = ctl_reg[port_prio_pkg::host_thr_lsb +: 4];
    end
  end

  // external port gate for a non-rate-limited host receive thread
  assign host_send_allowed = IS_HOST_PORT ? 1'b1 :
    ({1'b0, free_tx_blocks} >= {2'b00, ctl_reg[port_prio_pkg::host_thr_lsb +: 4]});

endmodule

/* switch_port_priority_regs_chk.sv */
// assertion checker for the port priority register bank
module switch_port_priority_regs_chk #(
  parameter bit IS_HOST_PORT = 1'b0
) (
  input wire logic                      clock,
  input wire logic                      rst_b,
  input wire logic                      clk_en,
  input wire port_prio_pkg::reg_req_t   reg_req,
  input wire logic [31:0]               reg_rdata,
  input wire logic [4:0]                free_tx_blocks,
  input wire logic                      host_send_allowed,
  input wire logic [15:0]               default_tag,
  input wire port_prio_pkg::prio_ctl_t  prio_ctl
);
  default clocking @(posedge clock);
  endclocking
  default disable iff (!rst_b);
  wire rd_ok = clk_en && reg_req.rd;
  wire wr_ok = clk_en && reg_req.wr;
  wire wr_ctl = wr_ok && reg_req.addr == port_prio_pkg::off_prio_control;

  blk_rsvd_a: assert property (rd_ok && reg_req.addr == port_prio_pkg::off_block_usage
    |=> (reg_rdata & 32'hffff_e0c0) == 32'h0000_0000) else $error("block usage reserved set");
  tx_rsvd_a: assert property (rd_ok && reg_req.addr == port_prio_pkg::off_tx_remap
    |=> (reg_rdata & 32'h8888_8888) == 32'h0000_0000) else $error("tx remap reserved set");
  rx_rsvd_a: assert property (rd_ok && reg_req.addr == port_prio_pkg::off_rx_remap
    |=> (reg_rdata & 32'h8888_8888) == 32'h0000_0000) else $error("rx remap reserved set");
  tag_out_a: assert property (wr_ok && reg_req.addr == port_prio_pkg::off_default_tag
    |=> default_tag == $past(reg_req.wdata[15:0])) else $error("default tag not updated");
  rx_pfc_a: assert property (wr_ctl
    |=> prio_ctl.rx_pfc_enable == $past(reg_req.wdata[23:16])) else $error("rx pfc wrong");
  tx_pfc_a: assert property (!IS_HOST_PORT && wr_ctl
    |=> prio_ctl.tx_pfc_enable == $past(reg_req.wdata[31:24])) else $error("tx pfc wrong");
  egress_a: assert property (!IS_HOST_PORT && wr_ctl
    |=> prio_ctl.ext_egress_limited == $past(reg_req.wdata[7:0])) else $error("egress wrong");
  send_gate_a: assert property (!IS_HOST_PORT
    |-> host_send_allowed == (free_tx_blocks >= {1'b0, prio_ctl.host_send_free_block_threshold}))
    else $error("send gate wrong");
endmodule
bind switch_port_priority_regs switch_port_priority_regs_chk #(.IS_HOST_PORT(IS_HOST_PORT)) chk_u (
  .clock(clock), .rst_b(rst_b), .clk_en(clk_en), .reg_req(reg_req), .reg_rdata(reg_rdata),
  .free_tx_blocks(free_tx_blocks), .host_send_allowed(host_send_allowed),
  .default_tag(default_tag), .prio_ctl(prio_ctl));

/* tb.sv */
// self-checking bench for the port priority register bank, external port layout
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic                     clock = 0;
  logic                     rst_b = 0;
  logic                     en = 1;
  port_prio_pkg::reg_req_t  req = '0;
  logic [31:0]              rdata;
  logic                     rx_up = 0, tx_up = 0;
  logic [5:0]               rx_val = 6'h00;
  logic [4:0]               tx_val = 5'h00;
  logic [2:0]               tx_hdr = 3'h0, tx_sw, rx_pkt = 3'h0, rx_hdr;
  logic [4:0]               free_blk = 5'h00;
  logic                     send_ok;
  logic [15:0]              tag;
  port_prio_pkg::prio_ctl_t ctl;
  int                       num_errors = 0, n_checks = 0, cycles = 0;
  switch_port_priority_regs #(.IS_HOST_PORT(1'b0)) dut_u (
    .clock(clock), .rst_b(rst_b), .clk_en(en), .reg_req(req), .reg_rdata(rdata),
    .rx_blocks_update(rx_up), .rx_blocks_value(rx_val), .tx_blocks_update(tx_up),
    .tx_blocks_value(tx_val), .tx_hdr_priority(tx_hdr), .tx_switch_priority(tx_sw),
    .rx_pkt_priority(rx_pkt), .rx_hdr_priority(rx_hdr), .free_tx_blocks(free_blk),
    .host_send_allowed(send_ok), .default_tag(tag), .prio_ctl(ctl));
  always #20 clock = ~clock;
  task automatic chk(input string what, input logic [63:0] exp, input logic [63:0] got);
    n_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    @(posedge clock);
    req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clock);
    req.wr <= 1'b0;
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] exp);
    @(posedge clock);
    req <= '{addr: a, wdata: 32'h0000_0000, wr: 1'b0, rd: 1'b1};
    @(posedge clock);
    req.rd <= 1'b0;
    @(negedge clock);
    chk("read data", exp, rdata);
  endtask
  task automatic stop_test();
    $display("checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  always @(posedge clock) begin
    cycles++;
    if (cycles == 5000) begin
      num_errors++;
      stop_test();
    end
  end
  logic [11:0] offs [5] = '{12'h004, 12'h008, 12'h00c, 12'h010, 12'h014};
  logic [31:0] rst_v [5] = '{32'h0000_0001, 0, 32'h7654_3210, 32'h0000_9000, 32'h7654_3210};
  logic [31:0] ones_v [5] = '{32'h0000_0001, 32'h0000_ffff, 32'h7777_7777, 32'hffff_f0ff,
                              32'h7777_7777};
  initial begin
    repeat (12) @(posedge clock);
    rst_b <= 1'b1;
    rd(12'h000, 32'h0000_0000);
    foreach (offs[i]) rd(offs[i], rst_v[i]);
    foreach (offs[i]) begin
      wr(offs[i], 32'hffff_ffff);
      rd(offs[i], ones_v[i]);
    end
    @(posedge clock);
    {rx_up, tx_up, rx_val, tx_val} <= {2'b11, 6'h3f, 5'h1f};
    @(posedge clock);
    {rx_up, tx_up} <= 2'b00;
    rd(12'h004, 32'h0000_1f3f);
    wr(12'h00c, 32'h0123_4567);
    wr(12'h014, 32'h0123_4567);
    for (int k = 0; k < 8; k++) begin
      @(posedge clock);
      {tx_hdr, rx_pkt} <= {3'(k), 3'(k)};
      @(posedge clock);
      @(negedge clock);
      chk("tx switch prio", 32'(7 - k), 32'(tx_sw));
      chk("rx header prio", 32'(7 - k), 32'(rx_hdr));
    end
    wr(12'h008, 32'hffff_b123);
    @(negedge clock);
    chk("default tag", 32'h0000_b123, 32'(tag));
    wr(12'h010, 32'ha5c3_c0e0);
    @(negedge clock);
    chk("control out", 64'({8'hc3, 8'ha5, 1'b0, 8'h00, 8'he0, 4'hc}), 64'(ctl));
    for (int f = 0; f < 32; f++) begin
      @(posedge clock);
      free_blk <= 5'(f);
      @(negedge clock);
      chk("send allowed", 32'(f >= 12), 32'(send_ok));
    end
    @(posedge clock);
    en <= 1'b0;
    wr(12'h008, 32'h0000_0001);
    en <= 1'b1;
    rd(12'h008, 32'h0000_b123);
    stop_test();
  end
endmodule
